// ---- logic/btm_top.sv ----
// Summary of operation
// - Test mode offers only NAND chain, drive-high and drive-low functions.
// - Trigger rising edge latches qualifiers; a match enters test mode.
// - A mismatch at the trigger edge selects normal operation, also leaving a test mode already entered.
// - In test mode with trigger held high, the NAND chain is active.
// - Input and bidirectional pins feed the chain so their continuity shows.
// - Chain starts at pin 206 and its result appears on pin 25.
// - Chain members and order follow the listed pins; others are excluded.
// - In test mode with trigger low, drive-high or drive-low pattern applies.
// - Pin 146 level selects drive-high or drive-low mode.
// - Drive-high: odd listed pins low, even listed pins high.
// - Drive-low: even listed pins low, odd listed pins high.
`timescale 1ns/1ps

module btm_top (
    input wire logic clock_i, // 125 MHz clock.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic trigger_i, // Trigger pin 99.
    input wire logic [btm_pkg::QHI_W-1:0] qual_hi_i, // Pins 103, 146.
    input wire logic [btm_pkg::QLO_W-1:0] qual_lo_i, // Must-be-low pins.
    input wire logic [btm_pkg::CHAIN_LEN-1:0] chain_i, // Chain pins.
    output logic test_mode_o, // Test mode latched.
    output logic nand_mode_o, // NAND chain active.
    output logic chain_out_o, // Chain result, pin 25.
    output logic drive_oe_o, // Pattern pins driven.
    output logic [btm_pkg::EVEN_CNT-1:0] drive_even_o, // Even pins.
    output logic [btm_pkg::ODD_CNT-1:0] drive_odd_o // Odd pins.
);

    ////////////////////////////////////////////////////////////////////////

    btm_pkg::btm_regs_s regs_reg;
    btm_pkg::btm_regs_s regs_next;
    logic trig_rise;
    logic pattern_ok;
    logic mode_high;

    assign trig_rise = trigger_i & ~regs_reg.trig_prev;
    assign pattern_ok = (qual_hi_i == btm_pkg::QHI_MATCH) &&
                        (qual_lo_i == btm_pkg::QLO_MATCH);
    assign mode_high = qual_hi_i[btm_pkg::QHI_MODE_BIT];

    // The whole cascade settles within one clock. It is the longest path
    // of the block, accepted because the chain only serves board test.
    function automatic logic nand_chain(
        input logic [btm_pkg::CHAIN_LEN-1:0] pins
    );
        logic acc;
        acc = pins[0];
        for (int k = 1; k < btm_pkg::CHAIN_LEN; k++) begin
            acc = ~(acc & pins[k]);
        end
        return acc;
    endfunction

    // Pin 146 is a qualifier and the mode select at once; after entry the
    // tester may move it freely, since the pattern is only checked at edges.
    always_comb begin
        regs_next = regs_reg;
        regs_next.trig_prev = trigger_i;
        // A mismatching edge also drops a test mode already entered.
        if (trig_rise) begin
            regs_next.test_mode = pattern_ok;
        end
        if (!regs_next.test_mode) begin
            regs_next.state = btm_pkg::ST_NORMAL;
        end else if (trigger_i) begin
            regs_next.state = btm_pkg::ST_NAND;
        end else begin
            regs_next.state = btm_pkg::ST_DRIVE;
        end
        regs_next.chain_out = 1'h0;
        regs_next.drive_even = '0;
        regs_next.drive_odd = '0;
        unique case (regs_next.state)
            btm_pkg::ST_NORMAL: begin
                regs_next.chain_out = 1'h0;
            end
            btm_pkg::ST_NAND: begin
                regs_next.chain_out = nand_chain(chain_i);
            end
            btm_pkg::ST_DRIVE: begin
                // Selection by pin 146 level.
                if (mode_high) begin
                    regs_next.drive_even = '1;
                    regs_next.drive_odd = '0;
                end else begin
                    regs_next.drive_even = '0;
                    regs_next.drive_odd = '1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            regs_reg <= btm_pkg::REGS_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign test_mode_o = regs_reg.test_mode;
    assign nand_mode_o = regs_reg.state[btm_pkg::ST_NAND_BIT];
    assign drive_oe_o = regs_reg.state[btm_pkg::ST_DRIVE_BIT];
    assign chain_out_o = regs_reg.chain_out;
    assign drive_even_o = regs_reg.drive_even;
    assign drive_odd_o = regs_reg.drive_odd;

    ////////////////////////////////////////////////////////////////////////

    entry_match_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (trig_rise && pattern_ok) |=> (test_mode_o && nand_mode_o))
        else $error("matching trigger edge did not enter test mode");

    entry_refuse_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (trig_rise && !pattern_ok) |=> (!test_mode_o && !drive_oe_o))
        else $error("mismatching trigger edge entered test mode");

    nand_select_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (test_mode_o && trigger_i && $past(trigger_i)) |=> nand_mode_o)
        else $error("trigger held high in test mode without chain");

    drive_select_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (test_mode_o && !trigger_i) |=> (drive_oe_o && !nand_mode_o))
        else $error("trigger low in test mode without drive pattern");

    chain_result_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        nand_mode_o |-> (chain_out_o ==
            nand_chain($past(chain_i))))
        else $error("chain output does not follow the NAND cascade");

    drive_high_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (drive_oe_o && $past(mode_high)) |->
            (&drive_even_o && !(|drive_odd_o)))
        else $error("drive-high pattern wrong");

    drive_low_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (drive_oe_o && !$past(mode_high)) |->
            (!(|drive_even_o) && &drive_odd_o))
        else $error("drive-low pattern wrong");

    normal_quiet_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !test_mode_o |-> (!nand_mode_o && !drive_oe_o && !chain_out_o &&
            !(|drive_even_o) && !(|drive_odd_o)))
        else $error("test function active outside test mode");

    mode_hold_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (!trig_rise && test_mode_o) |=> test_mode_o)
        else $error("test mode dropped without trigger edge");

    entry_edge_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (!trig_rise && !test_mode_o) |=> !test_mode_o)
        else $error("test mode entered without a trigger edge");

    ////////////////////////////////////////////////////////////////////////
    // Each test function stays confined to its own mode.

    funcs_gated_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (nand_mode_o || drive_oe_o) |-> test_mode_o)
        else $error("test function active with test mode clear");

    chain_idle_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !nand_mode_o |-> !chain_out_o)
        else $error("chain output active outside chain operation");

    pattern_idle_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !drive_oe_o |-> (!(|drive_even_o) && !(|drive_odd_o)))
        else $error("pattern pins driven outside output tests");

    nand_hold_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (nand_mode_o && trigger_i) |=> nand_mode_o)
        else $error("chain dropped while trigger stayed high");

    nand_exit_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (nand_mode_o && !trigger_i) |=> (drive_oe_o && !nand_mode_o))
        else $error("trigger low did not leave the chain");

    drive_hold_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (drive_oe_o && !trigger_i) |=> drive_oe_o)
        else $error("drive pattern dropped while trigger stayed low");

    drive_exit_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (drive_oe_o && trigger_i) |=> !drive_oe_o)
        else $error("trigger edge left the drive pattern standing");

    mode_select_a: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (test_mode_o && !trigger_i) |=>
            ((drive_even_o[0] == $past(mode_high)) &&
            (drive_odd_o[0] != $past(mode_high))))
        else $error("pin 146 level did not pick the pattern");

    ////////////////////////////////////////////////////////////////////////
    // These two watch reset itself, so they carry no reset guard.

    reset_clear_a: assert property (
        @(posedge clock_i)
        srst_i |=> (!test_mode_o && !nand_mode_o && !drive_oe_o &&
            !chain_out_o))
        else $error("reset did not return to normal operation");

    release_edge_a: assert property (
        @(posedge clock_i)
        $fell(srst_i) |-> !trig_rise)
        else $error("trigger level at reset release taken as an edge");

endmodule

// ---- logic/btm_pkg.sv ----
package btm_pkg;

    // Chain inputs in chain order; index 0 is the first stage.
    localparam int CHAIN_LEN = 130;
    // Pattern pins that are driven in the output tests.
    localparam int EVEN_CNT = 73;
    localparam int ODD_CNT = 66;

    // Chain index k carries the device pin CHAIN_PIN[k].
    localparam int CHAIN_PIN [CHAIN_LEN] = '{
        206, 207, 208, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13, 14, 16, 17, 18,
        19, 20, 21, 22, 23, 24, 26, 28, 29, 30, 31, 32, 33, 34, 35,
        36, 39, 40, 41, 42, 47, 50, 51, 58, 59, 62, 63, 64, 65, 66, 67, 68,
        69, 70, 71, 72, 73, 74, 75, 76, 77, 80, 81, 82, 83, 84, 85, 86,
        87, 88, 89, 90, 91, 92, 93, 94, 99, 100, 101, 103, 105, 108, 109,
        110, 111, 112, 113, 116, 117, 118, 121, 122, 123, 124, 125, 126,
        127, 128, 129, 131, 132,
        133, 134, 135, 136, 137, 138, 139, 140, 143, 144, 145, 146, 148,
        149, 150, 151, 152, 153, 154, 155, 156, 157, 168, 169, 170, 171,
        192, 197, 198, 199, 202};

    // Bit k of the even and odd pattern buses drives the pin listed here.
    localparam int EVEN_PIN [EVEN_CNT] = '{
        8, 10, 12, 14, 16, 18, 20, 22, 24, 30, 32, 34, 36, 40, 42, 44, 46,
        48, 52, 54, 56, 62, 64, 66, 68, 70, 72, 74, 76, 80, 82, 84, 86, 88,
        90, 92, 98, 102, 104, 106, 108, 110, 116, 118, 122, 124, 126, 128,
        132, 134, 136, 138, 140, 148, 150, 152, 154, 160, 168, 170, 172,
        174, 176, 178, 180, 184, 186, 188, 190, 192, 194, 196, 204};
    localparam int ODD_PIN [ODD_CNT] = '{
        11, 13, 17, 19, 21, 23, 31, 33, 35, 39, 41, 45, 49, 53, 55, 57, 63,
        65, 67, 69, 71, 73, 75, 77, 81, 83, 85, 87, 89, 91, 95, 107, 109,
        111, 117, 121, 123, 125, 127, 129, 131, 133, 135, 137, 139, 149,
        151, 153, 155, 157, 169, 171, 173, 175, 177, 179, 181, 183, 185,
        187, 189, 191, 193, 195, 203, 205};

    // Qualifier pins that must be high: bit 0 is pin 146, bit 1 pin 103.
    localparam int QHI_W = 2;
    localparam int QHI_MODE_BIT = 0;
    localparam logic [QHI_W-1:0] QHI_MATCH = 2'h3;
    // Qualifier pins that must be low: 29, 50, 100, 108, 145, 94.
    localparam int QLO_W = 6;
    localparam logic [QLO_W-1:0] QLO_MATCH = 6'h00;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h1,
        ST_NAND = 3'h2,
        ST_DRIVE = 3'h4
    } btm_state_e;

    localparam int ST_NAND_BIT = 1;
    localparam int ST_DRIVE_BIT = 2;

    typedef struct packed {
        btm_state_e state;
        logic test_mode;
        logic trig_prev;
        logic chain_out;
        logic [EVEN_CNT-1:0] drive_even;
        logic [ODD_CNT-1:0] drive_odd;
    } btm_regs_s;

    // The trigger history resets high so a trigger already high at
    // release is not taken as a fresh edge.
    localparam btm_regs_s REGS_RESET = '{
        state: ST_NORMAL,
        test_mode: 1'h0,
        trig_prev: 1'h1,
        chain_out: 1'h0,
        drive_even: '0,
        drive_odd: '0};

endpackage

// ---- testbench/btm_ate.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Qualifier and trigger pins sit on the chain too, so each such chain bit
// is tied to that pin's qualifier or trigger level and the two can never disagree.
module btm_ate (
    input wire logic trig_i, // Trigger level.
    input wire logic [btm_pkg::QHI_W-1:0] hi_i, // Pins 146, 103.
    input wire logic [btm_pkg::QLO_W-1:0] lo_i, // Low group.
    input wire logic [btm_pkg::CHAIN_LEN-1:0] rnd_i, // Free pins.
    output logic trigger_o, // Pin 99.
    output logic [btm_pkg::QHI_W-1:0] qual_hi_o, // High group.
    output logic [btm_pkg::QLO_W-1:0] qual_lo_o, // Low group.
    output logic [btm_pkg::CHAIN_LEN-1:0] chain_o // Chain pins.
);
    always_comb begin
        trigger_o = trig_i;
        qual_hi_o = hi_i;
        qual_lo_o = lo_i;
        chain_o = rnd_i;
        for (int k = 0; k < btm_pkg::CHAIN_LEN; k++) begin
            case (btm_pkg::CHAIN_PIN[k])
                99: chain_o[k] = trig_i;
                146: chain_o[k] = hi_i[0];
                103: chain_o[k] = hi_i[1];
                29: chain_o[k] = lo_i[0];
                50: chain_o[k] = lo_i[1];
                100: chain_o[k] = lo_i[2];
                108: chain_o[k] = lo_i[3];
                145: chain_o[k] = lo_i[4];
                94: chain_o[k] = lo_i[5];
                default: ;
            endcase
        end
    end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic clock_i, srst_i, trig, tm, nm, co, oe;
    logic [1:0] hi, qh;
    logic [5:0] lo, ql;
    logic [btm_pkg::CHAIN_LEN-1:0] rnd, ch;
    logic [btm_pkg::EVEN_CNT-1:0] ev;
    logic [btm_pkg::ODD_CNT-1:0] od;
    logic [159:0] r;
    logic [31:0] seed;
    logic tr, ex;
    int bad_count, total_checks, cyc;
    btm_ate ate_u (.trig_i(trig), .hi_i(hi), .lo_i(lo), .rnd_i(rnd),
        .trigger_o(tr), .qual_hi_o(qh), .qual_lo_o(ql), .chain_o(ch));
    btm_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .trigger_i(tr),
        .qual_hi_i(qh), .qual_lo_i(ql), .chain_i(ch), .test_mode_o(tm),
        .nand_mode_o(nm), .chain_out_o(co), .drive_oe_o(oe),
        .drive_even_o(ev), .drive_odd_o(od));
    ////////////////////////////////////////////////////////////////////
    function automatic logic exp_chain(input logic [129:0] v);
        logic a;
        a = v[0];
        for (int k = 1; k < 130; k++) a = !(a && v[k]);
        return a;
    endfunction
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic roll();
        for (int i = 0; i < 5; i++) begin
            seed = xorshift(seed);
            r = {r[127:0], seed};
        end
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clock_i);
        #1;
    endtask
    task automatic enter(input logic [7:0] q);
        trig = 0;
        step();
        {hi, lo} = q;
        trig = 1;
        step();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 2000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        srst_i = 1'b1;
        {trig, hi, lo, rnd, r} = '0;
        seed = 32'h525E413B;
        repeat (4) @(posedge clock_i);
        #1 srst_i = 0;
        for (int b = 0; b < 8; b++) begin
            enter(8'hC0 ^ (8'h01 << b));
            chk(tm, 0);
        end
        $display("refusal test done");
        enter(8'hC0);
        chk(tm, 1);
        chk(nm, 1);
        // Qualifiers wander between edges; only the trigger edge counts.
        repeat (200) begin
            roll();
            rnd = r[129:0];
            {hi, lo} = r[137:130];
            #1 ex = exp_chain(ch);
            step();
            chk(co, ex);
            chk(tm, 1);
        end
        // Single low pins on an otherwise high chain, spread along it.
        for (int b = 1; b < btm_pkg::CHAIN_LEN; b += 42) begin
            {hi, lo} = 8'hFF;
            rnd = ~(130'h1 << b);
            #1 ex = exp_chain(ch);
            step();
            chk(co, ex);
        end
        $display("chain test done");
        hi = 2'h3;
        trig = 0;
        step();
        chk({nm, co, oe}, 3'h1);
        chk(ev, 128'({btm_pkg::EVEN_CNT{1'b1}}));
        chk(od, 0);
        hi = 2'h2;
        step();
        chk(ev, 0);
        chk(od, 128'({btm_pkg::ODD_CNT{1'b1}}));
        enter(8'h40);
        chk({tm, oe, nm}, 0);
        $display("drive test done");
        enter(8'hC0);
        chk(tm, 1'h1);
        srst_i = 1'b1;
        step();
        chk({tm, nm, oe, co}, 4'h0);
        srst_i = 1'b0;
        repeat (2) step();
        chk(tm, 1'h0);
        enter(8'hC0);
        chk({tm, nm}, 2'h3);
        $display("reset test done");
        report_and_stop();
    end
endmodule
